// ===== rtl/snap_pkg.sv
// constants for the event alarm snapshot block: register map, field
// positions, reset values and widths.
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
package snap_pkg;
    // data width of the register bus
    localparam int DATA_W = 32;
    // byte address width seen by the slave
    localparam int ADDR_W = 8;
    // width of the queued event count field
    localparam int COUNT_W = 8;
    // bits in one event record
    localparam int REC_W = 8;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ZERO_LIM_OFS = 8'h04;
    localparam logic [7:0] FREQ_LIM_OFS = 8'h08;
    localparam logic [7:0] PW_LIM_OFS = 8'h0C;
    localparam logic [7:0] ACCEL_LIM_OFS = 8'h10;
    localparam logic [7:0] RECORD_OFS = 8'h14;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;
    localparam logic [7:0] REP_FREQ_OFS = 8'h20;
    localparam logic [7:0] REP_RATE_OFS = 8'h24;

    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    // record register layout: flags low, count above
    localparam int REC_FLAG_LSB = 0;
    localparam int REC_CNT_LSB = 8;
    localparam int REC_VALID_BIT = 16;

    // flag positions inside one record
    localparam int ZERO_BIT = 0;
    localparam int AVG_ZERO_BIT = 1;
    localparam int OVER_BIT = 2;
    localparam int AVG_OVER_BIT = 3;
    localparam int WIDE_BIT = 4;
    localparam int AVG_WIDE_BIT = 5;
    localparam int SPEEDUP_BIT = 6;
    localparam int AVG_SPEEDUP_BIT = 7;

    // interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_EVT_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;

    // limit reset values
    localparam logic [31:0] LIM_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_32 = 32'h0000_0000;
endpackage : snap_pkg

// ===== rtl/record_queue.sv
// record queue: holds event records the owner has not read yet.
// assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module record_queue #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic push,
    input wire logic [W-1:0] push_data,
    input wire logic pop,
    output logic [W-1:0] pop_data,
    output logic [AW:0] count,
    output logic full,
    output logic empty
);
    // record storage
    logic [W-1:0] mem_q [DEPTH];
    // write and read pointers
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    // occupancy
    logic [AW:0] cnt_q;
    // qualified strobes
    logic do_push;
    logic do_pop;

    // a full queue refuses pushes, an empty one refuses pops
    assign do_push = push && (cnt_q != DEPTH[AW:0]);
    assign do_pop = pop && (cnt_q != '0);
    assign pop_data = mem_q[rd_q];
    assign count = cnt_q;
    assign full = (cnt_q == DEPTH[AW:0]);
    assign empty = (cnt_q == '0);

    // storage write, no reset needed on data
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem_q[wr_q] <= push_data;
        end
    end

    // pointers wrap at the depth
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
        end
    end

    // occupancy follows push and pop together
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else begin
            case ({do_push, do_pop})
                2'b10: cnt_q <= cnt_q + 1'b1;
                2'b01: cnt_q <= cnt_q - 1'b1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end
endmodule : record_queue

// ===== rtl/event_alarm_snapshot.sv
// event alarm snapshot: compares rate measurements against limits at each
// event trigger, queues one flag record per event unless the queue is full, and serves them over an
// avalon-mm slave with waitrequest.
// assumes measurements and trigger come from logic on ref_clk.
//
// Function
// - zero-rate flag: instantaneous frequency below zero limit
// - below zero limit, report frequency and rate zero
// - averaged zero-rate flag against same zero limit
// - over-frequency flag: instantaneous frequency above limit
// - averaged over-frequency flag against same limit
// - wide-pulse flag: pulse width above limit
// - averaged wide-pulse flag against same limit
// - speedup flag: acceleration above acceleration limit
// - averaged speedup flag against same limit
// - queue records, report count, zero means none
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module event_alarm_snapshot #(
    parameter int VAL_W = 32,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [snap_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [snap_pkg::DATA_W-1:0] avs_writedata,
    output logic [snap_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // measurement inputs
    input wire logic event_trig,
    input wire logic [VAL_W-1:0] inst_freq,
    input wire logic [VAL_W-1:0] avg_freq,
    input wire logic [VAL_W-1:0] inst_pulse_width,
    input wire logic [VAL_W-1:0] avg_pulse_width,
    input wire logic [VAL_W-1:0] inst_accel,
    input wire logic [VAL_W-1:0] avg_accel,
    // reported values and status
    output logic [VAL_W-1:0] rep_freq,
    output logic [VAL_W-1:0] rep_rate,
    output logic [snap_pkg::COUNT_W-1:0] queued_event_count,
    output logic irq
);
    // strictly-greater compare, shared by the frequency, pulse-width and acceleration limit checks
    function automatic logic above(input logic [VAL_W-1:0] v,
                                   input logic [VAL_W-1:0] lim);
        above = (v > lim);
    endfunction : above

    // strictly-less compare for the zero limit
    function automatic logic below(input logic [VAL_W-1:0] v,
                                   input logic [VAL_W-1:0] lim);
        below = (v < lim);
    endfunction : below

    // software registers
    logic [31:0] ctrl_q;
    logic [VAL_W-1:0] zero_lim_q;
    logic [VAL_W-1:0] freq_lim_q;
    logic [VAL_W-1:0] pw_lim_q;
    logic [VAL_W-1:0] accel_lim_q;
    logic [snap_pkg::IRQ_W-1:0] irq_stat_q;
    logic [snap_pkg::IRQ_W-1:0] irq_mask_q;
    // bus handshake state
    logic wait_q;
    logic [snap_pkg::DATA_W-1:0] rdata_q;
    // output flops
    logic [VAL_W-1:0] rep_freq_q;
    logic [VAL_W-1:0] rep_rate_q;
    logic [snap_pkg::COUNT_W-1:0] qcount_q;
    logic irq_q;
    // snapshot record built in the trigger cycle
    logic [snap_pkg::REC_W-1:0] snap_rec;
    // queue side signals
    logic [snap_pkg::REC_W-1:0] head_rec;
    logic [AW:0] q_count;
    logic q_full;
    logic q_empty;
    logic capture;
    logic pop_rec;
    // bus strobes
    logic req;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic [snap_pkg::DATA_W-1:0] rd_mux;
    logic zero_now;

    // a request is accepted in the cycle waitrequest stands low
    assign req = avs_read || avs_write;
    assign acc = req && !wait_q;
    assign wr_acc = avs_write && acc;
    assign rd_acc = avs_read && acc;

    // one combinational record from the current measurements
    always_comb begin
        snap_rec = '0;
        snap_rec[snap_pkg::ZERO_BIT] = below(inst_freq, zero_lim_q);
        snap_rec[snap_pkg::AVG_ZERO_BIT] = below(avg_freq, zero_lim_q);
        snap_rec[snap_pkg::OVER_BIT] = above(inst_freq, freq_lim_q);
        snap_rec[snap_pkg::AVG_OVER_BIT] = above(avg_freq, freq_lim_q);
        snap_rec[snap_pkg::WIDE_BIT] = above(inst_pulse_width, pw_lim_q);
        snap_rec[snap_pkg::AVG_WIDE_BIT] =
            above(avg_pulse_width, pw_lim_q);
        snap_rec[snap_pkg::SPEEDUP_BIT] = above(inst_accel, accel_lim_q);
        snap_rec[snap_pkg::AVG_SPEEDUP_BIT] =
            above(avg_accel, accel_lim_q);
    end

    // capture when enabled; a record is pushed at every clock edge that samples the trigger high while the queue is not full
    assign capture = event_trig && ctrl_q[snap_pkg::CTRL_EN_BIT];
    // reading the record register consumes the head record
    assign pop_rec = rd_acc && (avs_address == snap_pkg::RECORD_OFS);

    // pending records for an owner that falls behind
    record_queue #(
        .W(snap_pkg::REC_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_queue (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .push(capture),
        .push_data(snap_rec),
        .pop(pop_rec),
        .pop_data(head_rec),
        .count(q_count),
        .full(q_full),
        .empty(q_empty)
    );

    // waitrequest drops for one cycle, one cycle after a request starts
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 1'b1;
        end else if (req && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = snap_pkg::ZERO_32;
        case (avs_address)
            snap_pkg::CTRL_OFS: rd_mux = ctrl_q;
            snap_pkg::ZERO_LIM_OFS: rd_mux = 32'(zero_lim_q);
            snap_pkg::FREQ_LIM_OFS: rd_mux = 32'(freq_lim_q);
            snap_pkg::PW_LIM_OFS: rd_mux = 32'(pw_lim_q);
            snap_pkg::ACCEL_LIM_OFS: rd_mux = 32'(accel_lim_q);
            snap_pkg::RECORD_OFS: begin
                // head flags, count, valid; empty queue reads flags zero
                if (!q_empty) begin
                    rd_mux[snap_pkg::REC_FLAG_LSB +: snap_pkg::REC_W] =
                        head_rec;
                end
                rd_mux[snap_pkg::REC_CNT_LSB +: snap_pkg::COUNT_W] =
                    snap_pkg::COUNT_W'(q_count);
                rd_mux[snap_pkg::REC_VALID_BIT] = !q_empty;
            end
            snap_pkg::IRQ_STAT_OFS: rd_mux = 32'(irq_stat_q);
            snap_pkg::IRQ_MASK_OFS: rd_mux = 32'(irq_mask_q);
            snap_pkg::REP_FREQ_OFS: rd_mux = 32'(rep_freq_q);
            snap_pkg::REP_RATE_OFS: rd_mux = 32'(rep_rate_q);
            default: rd_mux = snap_pkg::ZERO_32;
        endcase
    end

    // read data is latched as waitrequest falls, valid while it is low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= snap_pkg::ZERO_32;
        end else if (avs_read && wait_q) begin
            rdata_q <= rd_mux;
        end
    end

    // control register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= snap_pkg::CTRL_RST;
        end else if (wr_acc && avs_address == snap_pkg::CTRL_OFS) begin
            // only the enable bit is implemented
            ctrl_q <= 32'(avs_writedata[snap_pkg::CTRL_EN_BIT]);
        end
    end

    // limit registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            zero_lim_q <= VAL_W'(snap_pkg::LIM_RST);
            freq_lim_q <= VAL_W'(snap_pkg::LIM_RST);
            pw_lim_q <= VAL_W'(snap_pkg::LIM_RST);
            accel_lim_q <= VAL_W'(snap_pkg::LIM_RST);
        end else if (wr_acc) begin
            case (avs_address)
                snap_pkg::ZERO_LIM_OFS: zero_lim_q <= VAL_W'(avs_writedata);
                snap_pkg::FREQ_LIM_OFS: freq_lim_q <= VAL_W'(avs_writedata);
                snap_pkg::PW_LIM_OFS: pw_lim_q <= VAL_W'(avs_writedata);
                snap_pkg::ACCEL_LIM_OFS: accel_lim_q <= VAL_W'(avs_writedata);
                default: zero_lim_q <= zero_lim_q;
            endcase
        end
    end

    // interrupt mask
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask_q <= '0;
        end else if (wr_acc && avs_address == snap_pkg::IRQ_MASK_OFS) begin
            irq_mask_q <= avs_writedata[snap_pkg::IRQ_W-1:0];
        end
    end

    // sticky status: write one clears, a new event in the same cycle wins
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_q <= '0;
        end else begin
            logic [snap_pkg::IRQ_W-1:0] set_v;
            logic [snap_pkg::IRQ_W-1:0] clr_v;
            set_v = '0;
            clr_v = '0;
            set_v[snap_pkg::IRQ_EVT_BIT] = capture && !q_full;
            set_v[snap_pkg::IRQ_OVF_BIT] = capture && q_full;
            if (wr_acc && avs_address == snap_pkg::IRQ_STAT_OFS) begin
                clr_v = avs_writedata[snap_pkg::IRQ_W-1:0];
            end
            irq_stat_q <= (irq_stat_q & ~clr_v) | set_v;
        end
    end

    // interrupt output registered from status and mask
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // reported values forced to zero under the zero limit
    assign zero_now = below(inst_freq, zero_lim_q);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rep_freq_q <= '0;
            rep_rate_q <= '0;
        end else if (zero_now) begin
            rep_freq_q <= '0;
            rep_rate_q <= '0;
        end else begin
            rep_freq_q <= inst_freq;
            rep_rate_q <= inst_accel;
        end
    end

    // queued count mirrored to a port flop
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            qcount_q <= '0;
        end else begin
            qcount_q <= snap_pkg::COUNT_W'(q_count);
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign rep_freq = rep_freq_q;
    assign rep_rate = rep_rate_q;
    assign queued_event_count = qcount_q;
    assign irq = irq_q;

    // checks on the snapshot and reporting logic
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    zero_flag_a: assert property (capture && q_empty && !pop_rec |=>
        head_rec[snap_pkg::ZERO_BIT] == $past(inst_freq < zero_lim_q))
        else $error("zero-rate flag wrong");
    rep_zero_a: assert property (zero_now |=>
        rep_freq == '0 && rep_rate == '0)
        else $error("reported values not zero");
    avg_zero_a: assert property (capture && q_empty |=>
        head_rec[snap_pkg::AVG_ZERO_BIT] == $past(avg_freq < zero_lim_q))
        else $error("averaged zero-rate flag wrong");
    over_flag_a: assert property (capture && q_empty |=>
        head_rec[snap_pkg::OVER_BIT] == $past(inst_freq > freq_lim_q))
        else $error("over-frequency flag wrong");
    avg_over_a: assert property (capture && q_empty |=>
        head_rec[snap_pkg::AVG_OVER_BIT] == $past(avg_freq > freq_lim_q))
        else $error("averaged over-frequency flag wrong");
    wide_flag_a: assert property (capture && q_empty |=>
        head_rec[snap_pkg::WIDE_BIT] == $past(inst_pulse_width > pw_lim_q))
        else $error("wide-pulse flag wrong");
    avg_wide_a: assert property (capture && q_empty |=>
        head_rec[snap_pkg::AVG_WIDE_BIT] == $past(avg_pulse_width > pw_lim_q))
        else $error("averaged wide-pulse flag wrong");
    speedup_flag_a: assert property (capture && q_empty |=>
        head_rec[snap_pkg::SPEEDUP_BIT] == $past(inst_accel > accel_lim_q))
        else $error("speedup flag wrong");
    avg_speedup_a: assert property (capture && q_empty |=>
        head_rec[snap_pkg::AVG_SPEEDUP_BIT] == $past(avg_accel > accel_lim_q))
        else $error("averaged speedup flag wrong");
    count_up_a: assert property (capture && !q_full && !pop_rec |=>
        ##1 queued_event_count == $past(queued_event_count) + 1'b1)
        else $error("queued count did not rise");
    snap_whole_a: assert property (capture && q_empty |=>
        head_rec == $past(snap_rec))
        else $error("record not taken in trigger cycle");
    wait_pulse_a: assert property ($rose(req) && wait_q |=>
        !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not one low cycle");

    // status, interrupt and read-data checks
    // an accepted event sets the event bit even under a clear
    stat_set_a: assert property (capture && !q_full |=>
        irq_stat_q[snap_pkg::IRQ_EVT_BIT])
        else $error("event status bit not set");
    // a dropped record sets the overflow bit
    ovf_set_a: assert property (capture && q_full |=>
        irq_stat_q[snap_pkg::IRQ_OVF_BIT])
        else $error("overflow status bit not set");
    // a full queue keeps its count when a record is dropped
    full_hold_a: assert property (capture && q_full && !pop_rec |=>
        q_count == $past(q_count))
        else $error("full queue count changed");
    // capture disabled pushes nothing
    no_capture_a: assert property (event_trig && !capture && !pop_rec |=>
        q_count == $past(q_count))
        else $error("record taken while capture disabled");
    // interrupt follows unmasked status one cycle later
    irq_level_a: assert property (1'b1 |=>
        irq == $past(|(irq_stat_q & irq_mask_q)))
        else $error("interrupt level wrong");
    // read data is the multiplexer value taken as waitrequest falls
    rd_data_a: assert property (avs_read && wait_q |=>
        avs_readdata == $past(rd_mux))
        else $error("read data not latched");

    capture_c: cover property (capture ##1 pop_rec);
    overflow_c: cover property (capture && q_full);
    zero_c: cover property (capture && snap_rec[snap_pkg::ZERO_BIT]);
    irq_c: cover property ($rose(irq));
endmodule : event_alarm_snapshot

// ===== tb/owner_model.sv
// owner controller model: avalon-mm master that reads event records.
// assumes one clock and reset shared with the slave; waits are ended
// only by the bench watchdog.
`timescale 1ns/1ps
module owner_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    output logic [snap_pkg::ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [snap_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [snap_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // bus idle from time zero
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
    end

    // one access: raise after an edge, hold until waitrequest is low
    task automatic access(input logic wr, input logic [7:0] addr,
                          input logic [31:0] wdata,
                          output logic [31:0] rdata);
        @(posedge ref_clk);
        avs_address <= addr;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wdata;
        // sample waitrequest at each edge; the request stays put meanwhile
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // written data no longer valid once released
        avs_writedata <= ~wdata;
    endtask : access
endmodule : owner_model

// ===== tb/event_alarm_snapshot_tb.sv
// testbench for the event alarm snapshot block: register access through
// the owner model, measurement vectors and event triggers from the bench.
// assumes the design package is compiled first.
`timescale 1ns/1ps
module event_alarm_snapshot_tb;
    // limits loaded for the flag tests
    localparam logic [31:0] ZLIM = 32'h0000_0064;
    localparam logic [31:0] FLIM = 32'h0000_03E8;
    localparam logic [31:0] PLIM = 32'h0000_0032;
    localparam logic [31:0] ALIM = 32'h0000_0014;
    logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, irq;
    logic [7:0] avs_address, queued_event_count;
    logic [31:0] avs_writedata, avs_readdata, rep_freq, rep_rate, rd_q;
    logic event_trig;
    logic [31:0] m [6]; // measurement inputs in port order
    logic [31:0] vec [4][6]; // flag test vectors
    int num_errors = 0;
    int num_checks = 0;

    event_alarm_snapshot dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .event_trig(event_trig), .inst_freq(m[0]), .avg_freq(m[1]),
        .inst_pulse_width(m[2]), .avg_pulse_width(m[3]),
        .inst_accel(m[4]), .avg_accel(m[5]), .rep_freq(rep_freq),
        .rep_rate(rep_rate), .queued_event_count(queued_event_count),
        .irq(irq));

    owner_model owner_u (.ref_clk(ref_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        owner_u.access(1'b1, a, d, unused);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        owner_u.access(1'b0, a, 32'h0000_0000, rd_q);
        chk(rd_q, exp);
    endtask : rdchk

    // drive measurements and the trigger after an edge
    task automatic drive(input logic t, input logic [31:0] v [6]);
        @(posedge ref_clk);
        event_trig <= t;
        for (int k = 0; k < 6; k++) begin
            m[k] <= v[k];
        end
    endtask : drive

    // trigger low, then let record, count and irq settle
    task automatic settle();
        @(posedge ref_clk);
        event_trig <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : settle

    // expected record flags from measurements and limits
    function automatic logic [7:0] flags_of(input logic [31:0] v [6]);
        logic [7:0] f;
        f[snap_pkg::ZERO_BIT] = v[0] < ZLIM;
        f[snap_pkg::AVG_ZERO_BIT] = v[1] < ZLIM;
        f[snap_pkg::OVER_BIT] = v[0] > FLIM;
        f[snap_pkg::AVG_OVER_BIT] = v[1] > FLIM;
        f[snap_pkg::WIDE_BIT] = v[2] > PLIM;
        f[snap_pkg::AVG_WIDE_BIT] = v[3] > PLIM;
        f[snap_pkg::SPEEDUP_BIT] = v[4] > ALIM;
        f[snap_pkg::AVG_SPEEDUP_BIT] = v[5] > ALIM;
        return f;
    endfunction : flags_of

    // verdict and end of run
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        stop_test();
    end

    // main sequence
    initial begin
        logic [7:0] ofs [11];
        logic [31:0] cnt;
        ofs = '{snap_pkg::CTRL_OFS, snap_pkg::ZERO_LIM_OFS,
                snap_pkg::FREQ_LIM_OFS, snap_pkg::PW_LIM_OFS,
                snap_pkg::ACCEL_LIM_OFS, snap_pkg::RECORD_OFS,
                snap_pkg::IRQ_STAT_OFS, snap_pkg::IRQ_MASK_OFS,
                snap_pkg::REP_FREQ_OFS, snap_pkg::REP_RATE_OFS, 8'h40};
        // boundary, low side, high side and mixed vectors
        vec = '{'{ZLIM, FLIM, PLIM, PLIM, ALIM, ALIM},
                '{32'h63, 32'h63, 32'h33, 32'h0, 32'h15, 32'h0},
                '{32'h3E9, 32'h3E9, 32'h0, 32'h33, 32'h0, 32'h15},
                '{32'h1F4, 32'h32, PLIM, 32'h33, 32'h15, ALIM}};
        rst_b = 1'b0;
        event_trig = 1'b0;
        for (int k = 0; k < 6; k++) begin
            m[k] = 32'h0000_0000;
        end
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;

        // reset values, unmapped and read-only places
        wr(snap_pkg::REP_FREQ_OFS, 32'hFFFF_FFFF);
        wr(8'h40, 32'hFFFF_FFFF);
        for (int i = 0; i < 11; i++) begin
            rdchk(ofs[i], (i == 0) ? snap_pkg::CTRL_RST : snap_pkg::ZERO_32);
        end
        $display("test reset values done");

        // back-to-back events with changing inputs, then drain
        wr(snap_pkg::ZERO_LIM_OFS, ZLIM);
        wr(snap_pkg::FREQ_LIM_OFS, FLIM);
        wr(snap_pkg::PW_LIM_OFS, PLIM);
        wr(snap_pkg::ACCEL_LIM_OFS, ALIM);
        wr(snap_pkg::IRQ_MASK_OFS, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            drive(1'b1, vec[i]);
        end
        settle();
        chk({24'h000000, queued_event_count}, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0000_0001);
        rdchk(snap_pkg::IRQ_STAT_OFS, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            owner_u.access(1'b0, snap_pkg::RECORD_OFS, 32'h0, rd_q);
            chk(rd_q & 32'h0001_00FF, {15'h0, 1'b1, 8'h00, flags_of(vec[i])});
        end
        rdchk(snap_pkg::RECORD_OFS, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        chk({24'h000000, queued_event_count}, 32'h0000_0000);
        $display("test flag records done");

        // interrupt clear and mask
        wr(snap_pkg::IRQ_STAT_OFS, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(snap_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        wr(snap_pkg::IRQ_MASK_OFS, 32'h0000_0000);
        drive(1'b1, vec[1]);
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(snap_pkg::IRQ_STAT_OFS, 32'h0000_0001);
        rdchk(snap_pkg::RECORD_OFS, 32'h0001_0153);
        wr(snap_pkg::IRQ_STAT_OFS, 32'h0000_0001);
        $display("test interrupt done");

        // reported frequency and rate forced to zero below the zero limit
        drive(1'b0, '{32'h63, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0});
        repeat (2) @(posedge ref_clk);
        chk(rep_freq, 32'h0000_0000);
        chk(rep_rate, 32'h0000_0000);
        rdchk(snap_pkg::REP_RATE_OFS, 32'h0000_0000);
        drive(1'b0, '{32'h64, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0});
        repeat (2) @(posedge ref_clk);
        chk(rep_freq, 32'h0000_0064);
        rdchk(snap_pkg::REP_RATE_OFS, 32'h0000_0007);
        $display("test reported values done");

        // fill past the queue depth, then drain to empty
        for (int i = 0; i < 17; i++) begin
            drive(1'b1, vec[0]);
        end
        settle();
        chk({24'h000000, queued_event_count}, 32'h0000_0010);
        rdchk(snap_pkg::IRQ_STAT_OFS, 32'h0000_0003);
        for (int i = 0; i < 16; i++) begin
            rdchk(snap_pkg::RECORD_OFS, 32'h0001_0000 | {16'h0,
                  8'(16 - i), 8'h00});
        end
        repeat (2) @(posedge ref_clk);
        chk({24'h000000, queued_event_count}, 32'h0000_0000);
        wr(snap_pkg::IRQ_STAT_OFS, 32'h0000_0003);
        $display("test queue overflow done");

        // capture disabled: no record
        wr(snap_pkg::CTRL_OFS, 32'h0000_0000);
        drive(1'b1, vec[1]);
        settle();
        cnt = {24'h000000, queued_event_count};
        chk(cnt, 32'h0000_0000);
        rdchk(snap_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        wr(snap_pkg::CTRL_OFS, snap_pkg::CTRL_RST);
        $display("test capture disable done");
        stop_test();
    end
endmodule : event_alarm_snapshot_tb
